// *** hw/rivs_vector_select.sv ***
// Reset and interrupt vector address selector for the core fetch unit.
// Assumes requests, accept and the select bit come from core-clock logic;
// the boot fuse is a static strap from outside and is synchronised.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Every reset cause uses vector 1, which by default is word address 0x0000.
// [R2] External request lines 0 and 1 use offsets 0x0001 and 0x0002.
// [R3] Pin-change groups 0, 1 and 2 use offsets 0x0003, 0x0004 and 0x0005.
// [R4] The watchdog time-out interrupt, not its reset, uses offset 0x0006.
// [R5] The second 8-bit timer uses 0x0007, 0x0008 and 0x0009 for match A, match B, overflow.
// [R6] The 16-bit timer uses 0x000A to 0x000D for capture, match A, match B, overflow.
// [R7] The first 8-bit timer uses 0x000E, 0x000F and 0x0010 for match A, match B, overflow.
// [R8] The serial peripheral transfer-done interrupt uses offset 0x0011.
// [R9] The USART uses 0x0012, 0x0013 and 0x0014 for receive, buffer empty, transmit done.
// [R10] The converter-done interrupt uses offset 0x0015.
// [R11] EEPROM ready, comparator, two-wire and self-program ready use 0x0016 to 0x0019.
// [R12] A programmed boot fuse starts execution after reset at the boot reset address.
// [R13] With the select bit set each vector is its offset plus the boot section start.
// [R14] The table base is 0x001, or the boot reset address plus one when the bit is set.
// [R15] Fuse value 1 means unprogrammed (reset at 0x000), value 0 means programmed.
// [R16] Among pending requests the lowest vector number is served first.
// [R17] Software sets the select bit before it enables any interrupt.
module rivs_vector_select #(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic boot_reset_fuse,
  input wire logic vector_table_select,
  input wire logic [ADDR_W-1:0] boot_reset_addr,
  input wire logic [rivs_pkg::IRQ_COUNT-1:0] irq_req,
  input wire logic irq_accept,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_load,
  output logic irq_pending,
  output logic [rivs_pkg::VEC_NUM_W-1:0] irq_vector,
  output logic [rivs_pkg::IRQ_COUNT-1:0] irq_clear,
  output logic boot_fuse_programmed
);
  import rivs_pkg::*;

  initial
  begin
    if (ADDR_W < 5 || ADDR_W > OFS_W)
      $error("rivs_vector_select: ADDR_W must be 5 to 16");
  end

  // ------------------------------------------------------------
  // Offset lookup and address arithmetic
  // ------------------------------------------------------------
  function automatic logic [OFS_W-1:0] offset_of(input logic [IRQ_IDX_W-1:0] idx);
    case (idx)
      5'h00: offset_of = OFS_EXT_IRQ_LINE0; // R2
      5'h01: offset_of = OFS_EXT_IRQ_LINE1; // R2
      5'h02: offset_of = OFS_PIN_CHANGE_GROUP0; // R3
      5'h03: offset_of = OFS_PIN_CHANGE_GROUP1; // R3
      5'h04: offset_of = OFS_PIN_CHANGE_GROUP2; // R3
      5'h05: offset_of = OFS_WATCHDOG_TIMEOUT_IRQ; // R4
      5'h06: offset_of = OFS_TIMER_B8_MATCH_A; // R5
      5'h07: offset_of = OFS_TIMER_B8_MATCH_B; // R5
      5'h08: offset_of = OFS_TIMER_B8_OVERFLOW; // R5
      5'h09: offset_of = OFS_TIMER_W16_CAPTURE; // R6
      5'h0a: offset_of = OFS_TIMER_W16_MATCH_A; // R6
      5'h0b: offset_of = OFS_TIMER_W16_MATCH_B; // R6
      5'h0c: offset_of = OFS_TIMER_W16_OVERFLOW; // R6
      5'h0d: offset_of = OFS_TIMER_A8_MATCH_A; // R7
      5'h0e: offset_of = OFS_TIMER_A8_MATCH_B; // R7
      5'h0f: offset_of = OFS_TIMER_A8_OVERFLOW; // R7
      5'h10: offset_of = OFS_SPI_TRANSFER_DONE_IRQ; // R8
      5'h11: offset_of = OFS_USART_RX_DONE_IRQ; // R9
      5'h12: offset_of = OFS_USART_TX_BUFFER_EMPTY_IRQ; // R9
      5'h13: offset_of = OFS_USART_TX_DONE_IRQ; // R9
      5'h14: offset_of = OFS_ADC_DONE_IRQ; // R10
      5'h15: offset_of = OFS_EEPROM_READY_IRQ; // R11
      5'h16: offset_of = OFS_ANALOG_COMP_IRQ; // R11
      5'h17: offset_of = OFS_TWO_WIRE_IRQ; // R11
      5'h18: offset_of = OFS_SELF_PROGRAM_READY_IRQ; // R11
      default: offset_of = OFS_RESET;
    endcase
  endfunction

  // Base is boot address when relocated; offset already carries the +1
  function automatic logic [ADDR_W-1:0] vector_addr(input logic [IRQ_IDX_W-1:0] idx,
                                                    input logic relocate,
                                                    input logic [ADDR_W-1:0] boot_addr);
    logic [ADDR_W-1:0] base;
    base = relocate ? boot_addr : '0; // R13 R14
    vector_addr = ADDR_W'(offset_of(idx)) + base; // R13 R14
  endfunction

  // ------------------------------------------------------------
  // Fuse synchroniser
  // ------------------------------------------------------------
  logic fuse_meta_reg;
  logic fuse_sync_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fuse_meta_reg <= FUSE_RESET_VAL;
      fuse_sync_reg <= FUSE_RESET_VAL;
    end
    else
    begin
      fuse_meta_reg <= boot_reset_fuse;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Priority selection
  // ------------------------------------------------------------
  rivs_sel_if #(.N(IRQ_COUNT), .IW(IRQ_IDX_W)) sel ();

  assign sel.req = irq_req;

  rivs_prio_enc #(.N(IRQ_COUNT), .IW(IRQ_IDX_W)) u_prio
  (
    .sel(sel.enc)
  );

  // ------------------------------------------------------------
  // Sequencer and outputs
  // ------------------------------------------------------------
  rivs_state_t state_reg;
  rivs_state_t state_next;
  logic [1:0] settle_cnt_reg;
  logic [1:0] settle_cnt_next;
  logic fuse_prog_reg;
  logic fuse_prog_next;
  logic [ADDR_W-1:0] fetch_addr_reg;
  logic [ADDR_W-1:0] fetch_addr_next;
  logic fetch_load_reg;
  logic fetch_load_next;
  logic pending_reg;
  logic pending_next;
  logic [IRQ_IDX_W-1:0] idx_reg;
  logic [IRQ_IDX_W-1:0] idx_next;
  logic [VEC_NUM_W-1:0] vector_reg;
  logic [VEC_NUM_W-1:0] vector_next;
  logic [IRQ_COUNT-1:0] clear_reg;
  logic [IRQ_COUNT-1:0] clear_next;
  logic take;

  // The cleared source needs one edge to drop its request, so the cycle after
  // a clear pulse is masked; otherwise the same vector would be offered twice.
  assign take = (state_reg == RIVS_ST_RUN) && pending_reg && irq_accept;

  always_comb
  begin
    state_next = state_reg;
    settle_cnt_next = settle_cnt_reg;
    fuse_prog_next = fuse_prog_reg;
    fetch_addr_next = fetch_addr_reg;
    fetch_load_next = 1'b0;
    clear_next = '0;
    pending_next = 1'b0;
    idx_next = idx_reg;
    vector_next = vector_reg;
    case (state_reg)
      RIVS_ST_SETTLE:
      begin
        settle_cnt_next = settle_cnt_reg + 2'h1;
        if (settle_cnt_reg == SYNC_CNT_LAST)
          state_next = RIVS_ST_RESET_LOAD;
      end
      RIVS_ST_RESET_LOAD:
      begin
        fuse_prog_next = (fuse_sync_reg == FUSE_PROGRAMMED); // R15
        fetch_addr_next = (fuse_sync_reg == FUSE_PROGRAMMED) ? boot_reset_addr // R12
                                                             : ADDR_W'(OFS_RESET); // R1
        fetch_load_next = 1'b1; // R1
        state_next = RIVS_ST_RUN;
      end
      RIVS_ST_RUN:
      begin
        pending_next = sel.found && !take && (clear_reg == '0);
        idx_next = sel.index; // R16
        vector_next = VEC_NUM_W'(sel.index) + VEC_FIRST_IRQ;
        if (take)
        begin
          fetch_addr_next = vector_addr(idx_reg, vector_table_select, boot_reset_addr);
          fetch_load_next = 1'b1;
          clear_next[idx_reg] = 1'b1;
        end
      end
      default:
      begin
        state_next = RIVS_ST_SETTLE;
        settle_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= RIVS_ST_SETTLE;
      settle_cnt_reg <= '0;
      fuse_prog_reg <= 1'b0;
      fetch_addr_reg <= '0;
      fetch_load_reg <= 1'b0;
      pending_reg <= 1'b0;
      idx_reg <= '0;
      vector_reg <= '0;
      clear_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      settle_cnt_reg <= settle_cnt_next;
      fuse_prog_reg <= fuse_prog_next;
      fetch_addr_reg <= fetch_addr_next;
      fetch_load_reg <= fetch_load_next;
      pending_reg <= pending_next;
      idx_reg <= idx_next;
      vector_reg <= vector_next;
      clear_reg <= clear_next;
    end
  end

  assign fetch_addr = fetch_addr_reg;
  assign fetch_load = fetch_load_reg;
  assign irq_pending = pending_reg;
  assign irq_vector = vector_reg;
  assign irq_clear = clear_reg;
  assign boot_fuse_programmed = fuse_prog_reg;

endmodule // rivs_vector_select
`default_nettype wire

// *** include/rivs_pkg.sv ***
// Constants for the reset and interrupt vector address selector.
// Assumes a word-addressed program memory and one core clock.
package rivs_pkg;

  // ------------------------------------------------------------
  // Source count and widths
  // ------------------------------------------------------------
  localparam int IRQ_COUNT = 25;
  localparam int IRQ_IDX_W = 5;
  localparam int VEC_NUM_W = 5;
  localparam int OFS_W = 16;
  localparam logic [VEC_NUM_W-1:0] VEC_FIRST_IRQ = 5'h02;

  // ------------------------------------------------------------
  // Table offsets (word addresses)
  // ------------------------------------------------------------
  localparam logic [OFS_W-1:0] OFS_RESET = 16'h0000;
  localparam logic [OFS_W-1:0] OFS_EXT_IRQ_LINE0 = 16'h0001;
  localparam logic [OFS_W-1:0] OFS_EXT_IRQ_LINE1 = 16'h0002;
  localparam logic [OFS_W-1:0] OFS_PIN_CHANGE_GROUP0 = 16'h0003;
  localparam logic [OFS_W-1:0] OFS_PIN_CHANGE_GROUP1 = 16'h0004;
  localparam logic [OFS_W-1:0] OFS_PIN_CHANGE_GROUP2 = 16'h0005;
  localparam logic [OFS_W-1:0] OFS_WATCHDOG_TIMEOUT_IRQ = 16'h0006;
  localparam logic [OFS_W-1:0] OFS_TIMER_B8_MATCH_A = 16'h0007;
  localparam logic [OFS_W-1:0] OFS_TIMER_B8_MATCH_B = 16'h0008;
  localparam logic [OFS_W-1:0] OFS_TIMER_B8_OVERFLOW = 16'h0009;
  localparam logic [OFS_W-1:0] OFS_TIMER_W16_CAPTURE = 16'h000a;
  localparam logic [OFS_W-1:0] OFS_TIMER_W16_MATCH_A = 16'h000b;
  localparam logic [OFS_W-1:0] OFS_TIMER_W16_MATCH_B = 16'h000c;
  localparam logic [OFS_W-1:0] OFS_TIMER_W16_OVERFLOW = 16'h000d;
  localparam logic [OFS_W-1:0] OFS_TIMER_A8_MATCH_A = 16'h000e;
  localparam logic [OFS_W-1:0] OFS_TIMER_A8_MATCH_B = 16'h000f;
  localparam logic [OFS_W-1:0] OFS_TIMER_A8_OVERFLOW = 16'h0010;
  localparam logic [OFS_W-1:0] OFS_SPI_TRANSFER_DONE_IRQ = 16'h0011;
  localparam logic [OFS_W-1:0] OFS_USART_RX_DONE_IRQ = 16'h0012;
  localparam logic [OFS_W-1:0] OFS_USART_TX_BUFFER_EMPTY_IRQ = 16'h0013;
  localparam logic [OFS_W-1:0] OFS_USART_TX_DONE_IRQ = 16'h0014;
  localparam logic [OFS_W-1:0] OFS_ADC_DONE_IRQ = 16'h0015;
  localparam logic [OFS_W-1:0] OFS_EEPROM_READY_IRQ = 16'h0016;
  localparam logic [OFS_W-1:0] OFS_ANALOG_COMP_IRQ = 16'h0017;
  localparam logic [OFS_W-1:0] OFS_TWO_WIRE_IRQ = 16'h0018;
  localparam logic [OFS_W-1:0] OFS_SELF_PROGRAM_READY_IRQ = 16'h0019;

  // ------------------------------------------------------------
  // Fuse encoding, reset values and timing
  // ------------------------------------------------------------
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic FUSE_RESET_VAL = 1'b1;
  localparam int SYNC_CYCLES = 2;
  localparam logic [1:0] SYNC_CNT_LAST = 2'(SYNC_CYCLES - 1);

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RIVS_ST_SETTLE = 2'b00,
    RIVS_ST_RESET_LOAD = 2'b01,
    RIVS_ST_RUN = 2'b10
  } rivs_state_t;

endpackage

// *** include/rivs_sel_if.sv ***
// Request vector and winner index between the selector and its encoder.
// Assumes both ends sit on the same clock; the link is combinational.
`timescale 1ns/1ps
`default_nettype none
interface rivs_sel_if #(
  parameter int N = 25,
  parameter int IW = 5
);
  logic [N-1:0] req;
  logic found;
  logic [IW-1:0] index;

  modport enc
  (
    input req,
    output found,
    output index
  );
  modport user
  (
    output req,
    input found,
    input index
  );
endinterface
`default_nettype wire

// *** hw/rivs_prio_enc.sv ***
// Lowest-index-wins priority encoder over the pending request vector.
// Assumes a consumer that registers the result on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rivs_prio_enc #(
  parameter int N = 25,
  parameter int IW = 5
)
(
  rivs_sel_if.enc sel
);

  initial
  begin
    if (N < 1 || (1 << IW) < N)
      $error("rivs_prio_enc: index too narrow for N");
  end

  // Scan downward so the lowest set bit is the last to write
  always_comb
  begin
    sel.found = 1'b0;
    sel.index = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (sel.req[i])
      begin
        sel.found = 1'b1;
        sel.index = IW'(i);
      end
    end
  end

endmodule // rivs_prio_enc
`default_nettype wire

// *** dv/rivs_vector_select_sva.sv ***
// Checker for the vector address selector, sees only its top ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rivs_vector_select_sva
  import rivs_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic boot_reset_fuse,
  input wire logic vector_table_select,
  input wire logic [ADDR_W-1:0] boot_reset_addr,
  input wire logic [rivs_pkg::IRQ_COUNT-1:0] irq_req,
  input wire logic irq_accept,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_load,
  input wire logic irq_pending,
  input wire logic [rivs_pkg::VEC_NUM_W-1:0] irq_vector,
  input wire logic [rivs_pkg::IRQ_COUNT-1:0] irq_clear,
  input wire logic boot_fuse_programmed
);
  // ----------
  // Helpers
  // ----------
  logic [VEC_NUM_W-1:0] low_vec;
  always_comb
  begin
    low_vec = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--)
      if (irq_req[i])
        low_vec = VEC_NUM_W'(i + 2);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_settle;
    !fetch_load [*3];
  endsequence
  sequence s_taken;
    !$past(rst) && $past(irq_pending && irq_accept);
  endsequence
  // ----------
  // Properties
  // ----------
  a_reset_load_time: assert property ($fell(rst) |-> s_settle ##[1:2] fetch_load)
    else $error("reset load not at its slot");
  a_reset_addr_pick: assert property (fetch_load && !$past(irq_pending && irq_accept)
    |-> fetch_addr == (boot_reset_fuse ? '0 : boot_reset_addr))
    else $error("reset address wrong");
  a_fuse_flag_read: assert property (fetch_load && !$past(irq_pending && irq_accept)
    |-> boot_fuse_programmed == !boot_reset_fuse)
    else $error("fuse reading wrong");
  a_irq_addr_map: assert property (s_taken |-> fetch_load && fetch_addr ==
    ADDR_W'($past(irq_vector) - 5'h01) + ($past(vector_table_select) ? boot_reset_addr : '0))
    else $error("interrupt address wrong");
  a_clear_one_hot: assert property (s_taken
    |-> irq_clear == (25'h1 << ($past(irq_vector) - 5'h02)))
    else $error("clear pulse wrong");
  a_prio_lowest: assert property ($rose(irq_pending) |-> irq_vector == $past(low_vec))
    else $error("not the lowest pending vector");
  a_accept_drops: assert property (irq_pending && irq_accept |=> !irq_pending ##1 !irq_pending)
    else $error("offer not withdrawn after accept");
  a_vector_range: assert property (irq_pending |-> irq_vector >= 5'h02 && irq_vector <= 5'h1a)
    else $error("vector number out of range");
  a_clear_with_load: assert property (irq_clear != '0 |-> fetch_load ##1 irq_clear == '0)
    else $error("clear without load");
endmodule // rivs_vector_select_sva
bind rivs_vector_select rivs_vector_select_sva #(.ADDR_W(ADDR_W)) i_sva (.ref_clk, .rst,
  .boot_reset_fuse, .vector_table_select, .boot_reset_addr, .irq_req, .irq_accept,
  .fetch_addr, .fetch_load, .irq_pending, .irq_vector, .irq_clear, .boot_fuse_programmed);
`default_nettype wire

// *** dv/rivs_core_model.sv ***
// Core fetch model: takes each offered interrupt after a set wait.
// Assumes the selector's outputs change only at rising edges.
`timescale 1ns/1ps
`default_nettype none
module rivs_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_pending,
  input wire logic [3:0] wait_cycles,
  output logic irq_accept
);
  logic [3:0] cnt_reg;
  // Accept is a one-cycle pulse, dropped at the next edge, never raised without an offer
  always_ff @(posedge ref_clk)
  begin
    if (rst || !irq_pending || irq_accept)
    begin
      cnt_reg <= '0;
      irq_accept <= 1'b0;
    end
    else if (cnt_reg == wait_cycles)
      irq_accept <= 1'b1;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // rivs_core_model
`default_nettype wire

// *** dv/rivs_vector_select_tb.sv ***
// Self-checking bench for the vector address selector.
// Assumes the core model answers offers; sources drop on their clear pulse.
`timescale 1ns/1ps
`default_nettype none
module rivs_vector_select_tb;
  import rivs_pkg::*;
  logic ref_clk, rst, boot_reset_fuse, vector_table_select, irq_accept;
  logic fetch_load, irq_pending, boot_fuse_programmed;
  logic [11:0] boot_reset_addr, fetch_addr, exp_addr;
  logic [IRQ_COUNT-1:0] irq_req, irq_clear;
  logic [VEC_NUM_W-1:0] irq_vector;
  logic [3:0] wait_cycles;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [11:0] ofs_tab [25] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
    12'h007, 12'h008, 12'h009, 12'h00a, 12'h00b, 12'h00c, 12'h00d, 12'h00e, 12'h00f,
    12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h017, 12'h018, 12'h019};
  logic [11:0] prio_tab [3] = '{12'h001, 12'h006, 12'h019};
  rivs_vector_select #(.ADDR_W(12)) i_rivs_vector_select (.ref_clk, .rst, .boot_reset_fuse,
    .vector_table_select, .boot_reset_addr, .irq_req, .irq_accept, .fetch_addr, .fetch_load,
    .irq_pending, .irq_vector, .irq_clear, .boot_fuse_programmed);
  rivs_core_model i_rivs_core_model (.ref_clk, .rst, .irq_pending, .wait_cycles, .irq_accept);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  // Waits for a load, then lets the served source drop its request
  task automatic wait_load;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (fetch_load !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(n < 40, 32'h1, "load");
    irq_req = irq_req & ~irq_clear;
  endtask
  task automatic do_reset(input logic f);
    rst = 1'b1;
    boot_reset_fuse = f;
    repeat (10) @(negedge ref_clk);
    // Every output is cleared while reset is held
    check({fetch_load, irq_pending, irq_vector, irq_clear}, 32'h0, "outputs in reset");
    check({boot_fuse_programmed, fetch_addr}, 32'h0, "address in reset");
    rst = 1'b0;
    wait_load();
    check(fetch_addr, f ? 12'h000 : boot_reset_addr, "reset addr");
    check(boot_fuse_programmed, !f, "fuse flag");
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    boot_reset_fuse = 1'b1;
    vector_table_select = 1'b0;
    boot_reset_addr = 12'hc00;
    irq_req = '0;
    wait_cycles = 4'h0;
    @(negedge ref_clk);
    do_reset(1'b1);
    $display("test reset unprogrammed done");
    // ----------
    // Table rows
    // ----------
    for (int i = 0; i < 25; i++)
    begin
      @(negedge ref_clk);
      vector_table_select = i[0];
      wait_cycles = i[1] ? 4'h3 : 4'h0;
      irq_req[i] = 1'b1;
      exp_addr = ofs_tab[i] + (i[0] ? boot_reset_addr : 12'h000);
      wait_load();
      check(fetch_addr, exp_addr, "vector addr");
      check(irq_clear, 25'h1 << i, "clear");
      check(irq_vector, i + 2, "vector number");
      check(irq_pending, 32'h0, "offer withdrawn");
    end
    $display("test vector table done");
    // ----------
    // Hand-written cases
    // ----------
    @(negedge ref_clk);
    vector_table_select = 1'b0;
    irq_req = 25'h1000021;
    for (int k = 0; k < 3; k++)
    begin
      wait_load();
      check(fetch_addr, prio_tab[k], "priority order");
    end
    $display("test priority done");
    boot_reset_addr = 12'h780;
    do_reset(1'b0);
    @(negedge ref_clk);
    vector_table_select = 1'b1;
    irq_req[1] = 1'b1;
    wait_load();
    check(fetch_addr, 12'h782, "boot base");
    @(negedge ref_clk);
    vector_table_select = 1'b0;
    irq_req[2] = 1'b1;
    wait_load();
    check(fetch_addr, 12'h003, "low base");
    $display("test boot fuse done");
    end_of_test();
  end
endmodule // rivs_vector_select_tb
`default_nettype wire
